// ===== common/jlc_map.vh
// jlc_map.vh: register map, field positions, reset values and timing for
// the link control register block; definitions only.
`ifndef JLC_MAP_VH
`define JLC_MAP_VH
// register offsets on the CPU register port
`define JLC_CTRL_ONE_ADDR 8'h3A
`define JLC_CTRL_TWO_ADDR 8'h3B
// link_control_one fields
`define JLC_C1_IGNORE 7
`define JLC_C1_CLKSEL 6
`define JLC_C1_RATE_HI 5
`define JLC_C1_RATE_LO 4
`define JLC_C1_IRQ_EN 1
`define JLC_C1_WAIT_STOP 0
`define JLC_C1_RESET 8'hC0
`define JLC_C1_RW_MASK 8'hC3
// link_control_two fields
`define JLC_C2_ALOOP 7
`define JLC_C2_DLOOP 6
`define JLC_C2_FASTRX 5
`define JLC_C2_NBPOL 4
`define JLC_C2_EOD 3
`define JLC_C2_SINGLE 2
`define JLC_C2_MCRC 1
`define JLC_C2_MNOCRC 0
`define JLC_C2_RESET 8'hC0
// state vector value loaded on a received break
`define JLC_SVR_BREAK 8'h1C
// idle times after loopback release, microseconds (one link tick each)
`define JLC_EOF_TIME_US 240
`define JLC_IFS_TIME_US 300
`define JLC_IDLE_CNT_W 9
`endif

// ===== src/jlc_link_control.v
// jlc_link_control.v: control register logic of a byte-level single-wire
// link controller: both control registers, rate divider, loopback routing,
// idle gating, interrupt gating and in-frame response request encoding.
// Assumes the protocol handler runs on the same clock and gives pulses.
//
// Overview of operation
// [RULE_01] Ignore bit masks interrupts, holds status at reset, drops current frame.
// [RULE_02] Start-of-frame or break clears ignore bit; status and interrupts resume.
// [RULE_03] Clock select tells handler binary or integer link clock for symbol timing.
// [RULE_04] Rate code divides system clock by 1, 2, 4 or 8.
// [RULE_05] Rate bits take one write after reset, then read-only.
// [RULE_06] Software must not program divide-by-4 or divide-by-8.
// [RULE_07] Interrupt enable gates run-mode requests only; wake-ups always issue.
// [RULE_08] Request holds until all pending sources clear; disable may lose them.
// [RULE_09] Wait-clock bit stops internal clocks during CPU wait when set.
// [RULE_10] Analog loopback resets protocol state; after clear wait for end-of-frame.
// [RULE_11] After analog loopback clear: receive after EOF idle, transmit after IFS.
// [RULE_12] Digital loopback feeds receive from transmit and keeps transmit off pin.
// [RULE_13] Digital loopback clear: receive from pin after EOF/IFS idle times.
// [RULE_14] Fast receive: receive only at fourfold rate; else transmit and receive.
// [RULE_15] Received break clears fast receive and loads state vector with 1C.
// [RULE_16] Polarity bit chooses normalization bit value for CRC and non-CRC responses.
// [RULE_17] End-of-data sends CRC after current byte, or after shadow byte too.
// [RULE_18] Setting end-of-data clears the transmit-data-empty flag.
// [RULE_19] End-of-data clears on first CRC bit or error; in response on EOD.
// [RULE_20] Several response bits priority-encode internally; reads return written value.
// [RULE_21] Priority: single byte, then multi with CRC, then multi without CRC.
// [RULE_22] Software should set at most one response request bit.
// [RULE_23] Other control bits are readable and writable any time after reset.
`timescale 1ns/10ps
`default_nettype none
`include "jlc_map.vh"
module jlc_link_control (
   input wire clock,
   input wire reset,
   // cpu register port
   input wire [7:0] cpuAddr,
   input wire cpuWrite,
   input wire [7:0] cpuWrData,
   output reg [7:0] cpuRdData,
   // cpu power state
   input wire cpuWait,
   input wire cpuStop,
   // events from the protocol handler
   input wire sofSeen,
   input wire breakSeen,
   input wire errorSeen,
   input wire crcFirstBitRise,
   input wire eodSeen,
   input wire ifrDone,
   input wire txUnderrun,
   input wire txShadowFull,
   input wire busActivity,
   input wire irqPending,
   input wire tx_digital_output,
   // bus pins
   input wire rx_pin,
   output reg tx_pin,
   // to the protocol handler
   output reg rx_digital_input,
   output reg linkTick,
   output reg clockFreqBinary,
   output reg protocolReset,
   output reg rxAllowed,
   output reg txAllowed,
   output reg fastRxMode,
   output reg normBitCrc,
   output reg normBitNoCrc,
   output reg crcRequest,
   output reg crcAfterShadow,
   output reg tdreClear,
   output reg svrLoad,
   output reg [7:0] svrLoadValue,
   output reg statusHold,
   output reg frameDiscard,
   output reg [2:0] ifrActive,
   output reg clocksStopped,
   output reg irqOut
);

   // ==========================================================
   // helpers
   // ==========================================================
   function [2:0] ifrPriority;
      input [2:0] req;
      begin
         if (req[2]) begin
            ifrPriority = 3'h4;
         end else if (req[1]) begin
            ifrPriority = 3'h2;
         end else begin
            ifrPriority = {2'h0, req[0]};
         end
      end
   endfunction

   function [3:0] rateDivisor;
      input [1:0] code;
      begin
         case (code)
            2'h0: rateDivisor = 4'h1;
            2'h1: rateDivisor = 4'h2;
            2'h2: rateDivisor = 4'h4;
            default: rateDivisor = 4'h8;
         endcase
      end
   endfunction

   // ==========================================================
   // pin synchroniser
   // ==========================================================
   reg rxMeta_r;
   reg rxSync_r;
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         rxMeta_r <= 1'b0;
         rxSync_r <= 1'b0;
      end else begin
         rxMeta_r <= rx_pin;
         rxSync_r <= rxMeta_r;
      end
   end

   // ==========================================================
   // registers
   // ==========================================================
   reg [7:0] ctrlOne_r;
   reg [7:0] ctrlTwo_r;
   reg rateLocked_r;
   wire wrOne = cpuWrite && (cpuAddr == `JLC_CTRL_ONE_ADDR);
   wire wrTwo = cpuWrite && (cpuAddr == `JLC_CTRL_TWO_ADDR);
   wire eodSet = wrTwo && cpuWrData[`JLC_C2_EOD];
   wire [2:0] ifrInt = ifrPriority(ctrlTwo_r[2:0]);
   wire inIfr = |ifrInt;
   wire eodClear = errorSeen || (inIfr ? eodSeen : crcFirstBitRise);
   reg [7:0] ctrlOne_nxt;
   reg [7:0] ctrlTwo_nxt;

   always @* begin
      ctrlOne_nxt = ctrlOne_r;
      if (sofSeen || breakSeen) begin
         ctrlOne_nxt[`JLC_C1_IGNORE] = 1'b0; // RULE_02
      end
      if (wrOne) begin
         // a cpu write wins over a same-cycle hardware clear
         ctrlOne_nxt = (ctrlOne_nxt & ~`JLC_C1_RW_MASK)
            | (cpuWrData & `JLC_C1_RW_MASK); // RULE_23
         if (!rateLocked_r) begin
            ctrlOne_nxt[`JLC_C1_RATE_HI] = cpuWrData[`JLC_C1_RATE_HI]; // RULE_05
            ctrlOne_nxt[`JLC_C1_RATE_LO] = cpuWrData[`JLC_C1_RATE_LO]; // RULE_05
         end
      end
      ctrlTwo_nxt = ctrlTwo_r;
      if (breakSeen) begin
         ctrlTwo_nxt[`JLC_C2_FASTRX] = 1'b0; // RULE_15
      end
      if (eodClear) begin
         ctrlTwo_nxt[`JLC_C2_EOD] = 1'b0; // RULE_19
      end
      if (ifrInt[2] && (ifrDone || errorSeen || eodSet)) begin
         ctrlTwo_nxt[`JLC_C2_SINGLE] = 1'b0;
      end
      if ((ifrInt[1] || ifrInt[0]) && (ifrDone || errorSeen || txUnderrun)) begin
         ctrlTwo_nxt[`JLC_C2_MCRC] = 1'b0;
         ctrlTwo_nxt[`JLC_C2_MNOCRC] = 1'b0;
      end
      if (wrTwo) begin
         // raw written bits are kept so reads return them, except a pending single-byte request cleared by end-of-data
         ctrlTwo_nxt = cpuWrData; // RULE_20
         if (ifrInt[2] && eodSet) begin
            ctrlTwo_nxt[`JLC_C2_SINGLE] = 1'b0;
         end
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrlOne_r <= `JLC_C1_RESET;
         ctrlTwo_r <= `JLC_C2_RESET;
         rateLocked_r <= 1'b0;
      end else begin
         ctrlOne_r <= ctrlOne_nxt;
         ctrlTwo_r <= ctrlTwo_nxt;
         if (wrOne) begin
            rateLocked_r <= 1'b1; // RULE_05
         end
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         cpuRdData <= 8'h00;
      end else if (cpuAddr == `JLC_CTRL_ONE_ADDR) begin
         cpuRdData <= ctrlOne_r;
      end else if (cpuAddr == `JLC_CTRL_TWO_ADDR) begin
         cpuRdData <= ctrlTwo_r; // RULE_20
      end else begin
         cpuRdData <= 8'h00;
      end
   end

   // ==========================================================
   // rate divider
   // ==========================================================
   reg [3:0] divCount_r;
   wire [3:0] divLimit = rateDivisor({ctrlOne_r[`JLC_C1_RATE_HI],
      ctrlOne_r[`JLC_C1_RATE_LO]});
   wire divWrap = (divCount_r >= divLimit - 4'h1);
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         divCount_r <= 4'h0;
         linkTick <= 1'b0;
      end else begin
         divCount_r <= divWrap ? 4'h0 : divCount_r + 4'h1; // RULE_04
         linkTick <= divWrap && !clocksStopped; // RULE_09
      end
   end

   // ==========================================================
   // loopback release and idle gating
   // ==========================================================
   reg [`JLC_IDLE_CNT_W-1:0] idleCount_r;
   reg aloopPrev_r;
   reg dloopPrev_r;
   reg waitIdle_r;
   wire aloop = ctrlTwo_r[`JLC_C2_ALOOP];
   wire dloop = ctrlTwo_r[`JLC_C2_DLOOP];
   wire busIdle = dloop ? !tx_digital_output : !rxSync_r;
   wire released = (aloopPrev_r && !aloop) || (dloopPrev_r && !dloop);
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         idleCount_r <= {`JLC_IDLE_CNT_W{1'b0}};
         aloopPrev_r <= 1'b0;
         dloopPrev_r <= 1'b0;
         waitIdle_r <= 1'b1;
         rxAllowed <= 1'b0;
         txAllowed <= 1'b0;
      end else begin
         aloopPrev_r <= aloop;
         dloopPrev_r <= dloop;
         if (aloop || released) begin
            // analog loopback or any loopback release restarts the idle wait
            waitIdle_r <= 1'b1; // RULE_10
            idleCount_r <= {`JLC_IDLE_CNT_W{1'b0}};
            rxAllowed <= 1'b0;
            txAllowed <= 1'b0;
         end else if (waitIdle_r) begin
            if (!busIdle) begin
               idleCount_r <= {`JLC_IDLE_CNT_W{1'b0}};
            end else if (linkTick) begin
               idleCount_r <= idleCount_r + 1'b1;
            end
            if (idleCount_r >= `JLC_EOF_TIME_US) begin
               rxAllowed <= 1'b1; // RULE_11 RULE_13
            end
            if (idleCount_r >= `JLC_IFS_TIME_US) begin
               txAllowed <= 1'b1; // RULE_11 RULE_13
               waitIdle_r <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // pin routing and handler controls
   // ==========================================================
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         tx_pin <= 1'b0;
         rx_digital_input <= 1'b0;
         clockFreqBinary <= 1'b1;
         protocolReset <= 1'b1;
         fastRxMode <= 1'b0;
         normBitCrc <= 1'b0;
         normBitNoCrc <= 1'b1;
         crcRequest <= 1'b0;
         crcAfterShadow <= 1'b0;
         tdreClear <= 1'b0;
         svrLoad <= 1'b0;
         svrLoadValue <= 8'h00;
         statusHold <= 1'b1;
         frameDiscard <= 1'b1;
         ifrActive <= 3'h0;
      end else begin
         // passive low when the transmitter is cut off the pin
         tx_pin <= (dloop || ctrlTwo_r[`JLC_C2_FASTRX] || !txAllowed)
            ? 1'b0 : tx_digital_output; // RULE_12 RULE_14
         rx_digital_input <= dloop ? tx_digital_output : rxSync_r; // RULE_12 RULE_13
         clockFreqBinary <= ctrlOne_r[`JLC_C1_CLKSEL]; // RULE_03
         protocolReset <= aloop; // RULE_10
         fastRxMode <= ctrlTwo_r[`JLC_C2_FASTRX]; // RULE_14
         normBitCrc <= !ctrlTwo_r[`JLC_C2_NBPOL]; // RULE_16
         normBitNoCrc <= ctrlTwo_r[`JLC_C2_NBPOL]; // RULE_16
         crcRequest <= ctrlTwo_r[`JLC_C2_EOD]; // RULE_17
         if (eodSet && !ctrlTwo_r[`JLC_C2_EOD]) begin
            crcAfterShadow <= txShadowFull; // RULE_17
         end else if (!ctrlTwo_r[`JLC_C2_EOD]) begin
            crcAfterShadow <= 1'b0;
         end
         tdreClear <= eodSet; // RULE_18
         svrLoad <= breakSeen; // RULE_15
         svrLoadValue <= breakSeen ? `JLC_SVR_BREAK : 8'h00;
         statusHold <= ctrlOne_r[`JLC_C1_IGNORE]; // RULE_01
         frameDiscard <= ctrlOne_r[`JLC_C1_IGNORE]; // RULE_01
         ifrActive <= ifrInt; // RULE_20 RULE_21
      end
   end

   // ==========================================================
   // power state and interrupt request
   // ==========================================================
   wire stopNow = cpuStop || (cpuWait && ctrlOne_r[`JLC_C1_WAIT_STOP]);
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         clocksStopped <= 1'b0;
         irqOut <= 1'b0;
      end else begin
         // bus activity restarts the clocks and raises a wake-up
         clocksStopped <= stopNow && !busActivity; // RULE_09
         if (ctrlOne_r[`JLC_C1_IGNORE]) begin
            irqOut <= 1'b0; // RULE_01
         end else if ((cpuStop || cpuWait) && busActivity) begin
            irqOut <= 1'b1; // RULE_07
         end else begin
            // level follows the pending sources until all are cleared
            irqOut <= irqPending && ctrlOne_r[`JLC_C1_IRQ_EN]
               && !cpuWait && !cpuStop; // RULE_07 RULE_08
         end
      end
   end

endmodule // jlc_link_control
`default_nettype wire

// ===== dv/jlc_link_control_checker.sv
// jlc_link_control_checker.sv: port-level assertions for the link control block.
// Assumes it is bound into jlc_link_control and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "jlc_map.vh"
module jlc_link_control_checker (
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] cpuAddr,
   input wire logic cpuWrite,
   input wire logic [7:0] cpuWrData,
   input wire logic [7:0] cpuRdData,
   input wire logic breakSeen,
   input wire logic errorSeen,
   input wire logic svrLoad,
   input wire logic [7:0] svrLoadValue,
   input wire logic tdreClear,
   input wire logic normBitCrc,
   input wire logic normBitNoCrc,
   input wire logic [2:0] ifrActive,
   input wire logic rxAllowed,
   input wire logic txAllowed,
   input wire logic fastRxMode,
   input wire logic tx_pin,
   input wire logic crcRequest,
   input wire logic statusHold,
   input wire logic frameDiscard,
   input wire logic irqOut
);
   // ==========
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   chk_rd_unmapped: assert property (!($past(cpuAddr) inside {8'h3A, 8'h3B})
      |-> cpuRdData == 8'h00) else $error("unmapped read not zero");
   chk_rd_gap: assert property ($past(cpuAddr) == `JLC_CTRL_ONE_ADDR
      |-> cpuRdData[3:2] == 2'b00) else $error("unused bits read nonzero");
   chk_tx_data_empty_flag_pulse: assert property (cpuWrite && cpuAddr == `JLC_CTRL_TWO_ADDR
      && cpuWrData[`JLC_C2_EOD] |-> ##[1:2] tdreClear) else $error("no empty flag clear");
   chk_svr_load: assert property (breakSeen |-> ##[1:2] svrLoad)
      else $error("no state vector load");
   chk_svr_value: assert property (svrLoadValue == (svrLoad ? `JLC_SVR_BREAK : 8'h00))
      else $error("state vector value wrong");
   chk_nb_swap: assert property (normBitCrc != normBitNoCrc)
      else $error("normalization bits equal");
   chk_ifr_single: assert property ($onehot0(ifrActive))
      else $error("response request not encoded");
   chk_gate_order: assert property (txAllowed |-> rxAllowed)
      else $error("transmit gate before receive gate");
   chk_fast_quiet: assert property (fastRxMode && $past(fastRxMode) |-> !tx_pin)
      else $error("transmit during fast receive");
   chk_eod_error: assert property (errorSeen && !cpuWrite ##1 !cpuWrite
      |-> ##1 !crcRequest) else $error("end of data kept after error");
   chk_hold_pair: assert property (statusHold == frameDiscard)
      else $error("hold and discard differ");
   chk_hold_irq: assert property (statusHold |-> !irqOut)
      else $error("interrupt while ignoring");
   cover property (svrLoad);
   cover property (tdreClear);
   cover property (txAllowed);
endmodule // jlc_link_control_checker
bind jlc_link_control jlc_link_control_checker u_chk (.clock, .reset, .cpuAddr, .cpuWrite,
   .cpuWrData, .cpuRdData, .breakSeen, .errorSeen, .svrLoad, .svrLoadValue, .tdreClear,
   .normBitCrc, .normBitNoCrc, .ifrActive, .rxAllowed, .txAllowed, .fastRxMode, .tx_pin,
   .crcRequest, .statusHold, .frameDiscard, .irqOut);
`default_nettype wire

// ===== dv/jlc_bus_node.sv
// jlc_bus_node.sv: far-side bus node seen through the transceiver receive pin.
// Assumes the bench steers it; the bus rests low when nobody drives it.
`timescale 1ns/10ps
`default_nettype none
module jlc_bus_node (
   input wire logic clock,
   input wire logic drive,
   input wire logic level,
   output logic rxPin
);
   // released bus returns to the passive low level, never holds the last bit
   initial rxPin = 1'b0;
   always @(posedge clock) begin
      rxPin <= drive ? level : 1'b0;
   end
endmodule // jlc_bus_node
`default_nettype wire

// ===== dv/tb_top.sv
// tb_top.sv: self-checking bench for the link control block with a bus node.
// Assumes the design, its map header and the checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
`include "jlc_map.vh"
module tb_top;
   // ==========
   // signals
   logic clock = 0, reset = 1, cpuWrite = 0, cpuWait = 0, cpuStop = 0, txShadowFull = 0;
   logic busActivity = 0, irqPending = 0, txOut = 0, nodeDrive = 0, nodeLevel = 0, rateDone = 0;
   logic [6:0] ev = 7'h00;
   logic [7:0] cpuAddr = 8'h00, cpuWrData = 8'h00, c1m = 8'hC0, c2m = 8'hC0, d;
   logic [15:0] lfsr = 16'h639F;
   wire [7:0] cpuRdData, svrLoadValue;
   wire [2:0] ifrActive;
   wire rxPin, txPin, rxIn, linkTick, clkBin, protoRst, rxOk, txOk, fastRx, nbCrc, nbNoCrc;
   wire crcReq, crcShadow, tdreClr, svrLoad, stHold, frDisc, clkStop, irqOut;
   int mismatches = 0, num_checks = 0, cycles = 0, ticks, i;
   jlc_bus_node node (.clock(clock), .drive(nodeDrive), .level(nodeLevel), .rxPin(rxPin));
   jlc_link_control uut (.clock(clock), .reset(reset), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite),
      .cpuWrData(cpuWrData), .cpuRdData(cpuRdData), .cpuWait(cpuWait), .cpuStop(cpuStop),
      .sofSeen(ev[0]), .breakSeen(ev[1]), .errorSeen(ev[2]), .crcFirstBitRise(ev[3]),
      .eodSeen(ev[4]), .ifrDone(ev[5]), .txUnderrun(ev[6]), .txShadowFull(txShadowFull),
      .busActivity(busActivity), .irqPending(irqPending), .tx_digital_output(txOut),
      .rx_pin(rxPin), .tx_pin(txPin), .rx_digital_input(rxIn), .linkTick(linkTick),
      .clockFreqBinary(clkBin), .protocolReset(protoRst), .rxAllowed(rxOk), .txAllowed(txOk),
      .fastRxMode(fastRx), .normBitCrc(nbCrc), .normBitNoCrc(nbNoCrc), .crcRequest(crcReq),
      .crcAfterShadow(crcShadow), .tdreClear(tdreClr), .svrLoad(svrLoad),
      .svrLoadValue(svrLoadValue), .statusHold(stHold), .frameDiscard(frDisc),
      .ifrActive(ifrActive), .clocksStopped(clkStop), .irqOut(irqOut));
   // ==========
   // clock, watchdog, helpers
   always #10 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         mismatches = mismatches + 1;
         print_verdict();
      end
   end
   function automatic logic [15:0] nextRand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [2:0] pri(input logic [2:0] w);
      return w[2] ? 3'h4 : (w[1] ? 3'h2 : {2'b00, w[0]});
   endfunction
   task automatic cmpByte(input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t exp %h got %h", $time, exp, got);
      end
   endtask
   task automatic cmpBit(input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t exp %h got %h", $time, exp, got);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clock);
      cpuAddr = a;
      cpuWrData = v;
      cpuWrite = 1;
      @(negedge clock);
      cpuWrite = 0;
      if (a == `JLC_CTRL_ONE_ADDR) begin
         c1m = (v & `JLC_C1_RW_MASK) | (rateDone ? (c1m & 8'h30) : (v & 8'h30));
         rateDone = 1;
      end else if (a == `JLC_CTRL_TWO_ADDR) begin
         // end-of-data set by the cpu ends a pending single-byte response
         c2m = (c2m[2] && v[`JLC_C2_EOD]) ? (v & 8'hFB) : v;
      end
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clock);
      cpuAddr = a;
      @(negedge clock);
      cmpByte(exp, cpuRdData);
   endtask
   task automatic pulse(input int n);
      @(negedge clock);
      ev[n] = 1;
      @(negedge clock);
      ev[n] = 0;
   endtask
   task automatic print_verdict();
      if (mismatches == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==========
   // main sequence
   initial begin
      tk(10);
      reset = 0;
      rdChk(`JLC_CTRL_ONE_ADDR, `JLC_C1_RESET);
      rdChk(`JLC_CTRL_TWO_ADDR, `JLC_C2_RESET);
      rdChk(8'h3C, 8'h00);
      wr(`JLC_CTRL_ONE_ADDR, 8'h52);
      wr(`JLC_CTRL_ONE_ADDR, 8'h7E);
      rdChk(`JLC_CTRL_ONE_ADDR, c1m);
      cmpBit(1'b1, clkBin);
      ticks = 0;
      for (i = 0; i < 40; i++) begin
         @(negedge clock);
         ticks += linkTick;
      end
      cmpByte(8'h14, ticks[7:0]);
      irqPending = 1;
      tk(3);
      cmpBit(1'b1, irqOut);
      wr(`JLC_CTRL_ONE_ADDR, 8'h50);
      tk(3);
      cmpBit(1'b0, irqOut);
      cpuStop = 1;
      busActivity = 1;
      tk(3);
      cmpBit(1'b1, irqOut);
      cpuStop = 0;
      busActivity = 0;
      wr(`JLC_CTRL_ONE_ADDR, 8'h51);
      cpuWait = 1;
      tk(3);
      cmpBit(1'b1, clkStop);
      cpuWait = 0;
      wr(`JLC_CTRL_ONE_ADDR, 8'hD2);
      tk(2);
      cmpBit(1'b1, stHold);
      cmpBit(1'b0, irqOut);
      pulse(0);
      c1m = c1m & 8'h7F;
      rdChk(`JLC_CTRL_ONE_ADDR, c1m);
      cmpBit(1'b1, irqOut);
      irqPending = 0;
      // every response code, several set at once on purpose
      for (i = 0; i < 8; i++) begin
         lfsr = nextRand(lfsr);
         d = {lfsr[7:3], i[2:0]};
         if (d[2]) d[3] = 1'b0;
         wr(`JLC_CTRL_TWO_ADDR, d);
         tk(1);
         rdChk(`JLC_CTRL_TWO_ADDR, c2m);
         cmpByte({5'h00, pri(c2m[2:0])}, {5'h00, ifrActive});
         cmpBit(~c2m[4], nbCrc);
         cmpBit(c2m[3], crcReq);
         cmpBit(c2m[5], fastRx);
         cmpBit(c2m[7], protoRst);
      end
      txShadowFull = 1;
      wr(`JLC_CTRL_TWO_ADDR, 8'h08);
      tk(1);
      cmpBit(1'b1, crcShadow);
      pulse(3);
      rdChk(`JLC_CTRL_TWO_ADDR, 8'h00);
      txShadowFull = 0;
      wr(`JLC_CTRL_TWO_ADDR, 8'h08);
      pulse(2);
      rdChk(`JLC_CTRL_TWO_ADDR, 8'h00);
      wr(`JLC_CTRL_TWO_ADDR, 8'h0A);
      pulse(3);
      rdChk(`JLC_CTRL_TWO_ADDR, 8'h0A);
      pulse(4);
      rdChk(`JLC_CTRL_TWO_ADDR, 8'h02);
      pulse(6);
      rdChk(`JLC_CTRL_TWO_ADDR, 8'h00);
      wr(`JLC_CTRL_TWO_ADDR, 8'h20);
      pulse(1);
      rdChk(`JLC_CTRL_TWO_ADDR, 8'h00);
      cmpBit(1'b0, fastRx);
      wr(`JLC_CTRL_TWO_ADDR, 8'h40);
      txOut = 1;
      nodeDrive = 1;
      tk(4);
      cmpBit(1'b1, rxIn);
      cmpBit(1'b0, txPin);
      nodeDrive = 0;
      wr(`JLC_CTRL_TWO_ADDR, 8'h00);
      tk(2 * `JLC_EOF_TIME_US - 20);
      cmpBit(1'b0, rxOk);
      tk(40);
      cmpBit(1'b1, rxOk);
      cmpBit(1'b0, txOk);
      tk(2 * (`JLC_IFS_TIME_US - `JLC_EOF_TIME_US));
      cmpBit(1'b1, txOk);
      cmpBit(1'b1, txPin);
      nodeDrive = 1;
      nodeLevel = 1;
      tk(4);
      cmpBit(1'b1, rxIn);
      reset = 1;
      tk(2);
      reset = 0;
      rateDone = 0;
      wr(`JLC_CTRL_ONE_ADDR, 8'h40);
      rdChk(`JLC_CTRL_ONE_ADDR, c1m);
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
